/* hdl/pos_cfg.svh */
// configuration macros for the printer output serializer
`ifndef POS_CFG_SVH
`define POS_CFG_SVH

// ----------------------------------------------------------------------
// timing, as printed, and the clock period
// ----------------------------------------------------------------------
`define POS_CLK_NS 5
`define POS_TICK_NS 10000
`define POS_PULSE_NS 2000
`define POS_FRAME_US 9090
`define POS_STOP_US 18180
`define POS_NS_PER_US 1000

// ----------------------------------------------------------------------
// frame numbering: 0 start, 1..7 data bits 0..6, 8 parity
// ----------------------------------------------------------------------
`define POS_FRAME_START 4'h0
`define POS_DATA_FIRST 4'h1
`define POS_DATA_LAST 4'h7
`define POS_PARITY_FRAME 4'h8
`define POS_MARK 1'b1
`define POS_SPACE 1'b0

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define POS_OFF_W 8
`define POS_CTRL_OFF 8'h00
`define POS_STAT_OFF 8'h04
`define POS_CTRL_RST 4'h0
`define POS_B_OFFLINE 0
`define POS_B_PERF 1
`define POS_B_KB 2
`define POS_B_PRDY 3
`define POS_S_SREADY 0
`define POS_S_PEN 1
`define POS_S_REQ 2
`define POS_S_LINE 3
`define POS_S_STOP 4
`define POS_S_WORD_LO 8
`define POS_S_WORD_HI 15
`define POS_HTRANS_ACTIVE 1
`define POS_HRESP_OKAY 1'b0

`endif

/* hdl/pos_pkg.sv */
// types shared by the printer output serializer
package pos_pkg;

    typedef enum logic [1:0] {
        POS_IDLE = 2'b00,
        POS_SHIFT = 2'b01,
        POS_STOP = 2'b10
    } pos_state_t;

    typedef struct packed {
        logic printer_ready_flag;
        logic keyboard_active;
        logic perforator_active_flag;
        logic offline_flag;
    } pos_ctrl_t;

    typedef struct packed {
        logic out_word_ack;
        logic [7:0] out_word;
    } pos_host_in_t;

endpackage : pos_pkg

/* hdl/pos_pin_sync.sv */
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module pos_pin_sync #(
    parameter int W = 9
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    s1_q[i] <= 1'b0;
                    s2_q[i] <= 1'b0;
                    s3_q[i] <= 1'b0;
                    pin_q[i] <= 1'b0;
                end else begin
                    s1_q[i] <= pin_in[i];
                    s2_q[i] <= s1_q[i];
                    s3_q[i] <= s2_q[i];
                    // one-cycle glitches through stage two never reach the output
                    if (s2_q[i] == s3_q[i]) begin
                        pin_q[i] <= s3_q[i];
                    end
                end
            end
        end
    endgenerate
endmodule : pos_pin_sync

/* hdl/pos_serializer.sv */
// printer output serializer: host word handshake, teleprinter line and AHB-Lite registers
`timescale 1ns/1ps
`include "pos_cfg.svh"
module pos_serializer #(
    parameter int TICK_CYC = `POS_TICK_NS / `POS_CLK_NS
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire pos_pkg::pos_host_in_t host_pin,
    output logic out_word_request,
    output logic printer_serial_line,
    output logic function_word_request_gate
);
    // ------------------------------------------------------------------
    // derived counts
    // ------------------------------------------------------------------
    localparam int PULSE_CYC = (`POS_PULSE_NS + `POS_CLK_NS - 1) / `POS_CLK_NS;
    localparam int FRAME_TICKS = `POS_FRAME_US * `POS_NS_PER_US / `POS_TICK_NS;
    localparam int STOP_TICKS = `POS_STOP_US * `POS_NS_PER_US / `POS_TICK_NS;
    localparam int FRAME_CYC = FRAME_TICKS * TICK_CYC;
    localparam logic [8:0] PULSE_LD = 9'(PULSE_CYC);
    localparam logic [11:0] FRAME_LAST = 12'(FRAME_TICKS - 1);
    localparam logic [11:0] STOP_LAST = 12'(STOP_TICKS - 1);
    localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);

    // decides the line level for a frame of the character
    function automatic logic frame_level(input logic [3:0] frame, input logic [7:0] word);
        logic lvl;
        lvl = `POS_MARK;
        if (frame == `POS_FRAME_START || frame == `POS_PARITY_FRAME) begin
            lvl = `POS_SPACE;
        end else if (frame >= `POS_DATA_FIRST && frame <= `POS_DATA_LAST) begin
            lvl = word[3'(frame - `POS_DATA_FIRST)];
        end
        return lvl;
    endfunction : frame_level

    pos_pkg::pos_host_in_t host_s;
    pos_pkg::pos_ctrl_t ctrl_q;
    pos_pkg::pos_state_t state_q;
    logic [7:0] out_word_q;
    logic print_enable_flag_q;
    logic serializer_ready_flag_q;
    logic ack_prev_q;
    logic [8:0] load_cnt_q;
    logic [8:0] trig_cnt_q;
    logic [15:0] pre_q;
    logic [11:0] ftk_q;
    logic [3:0] frame_q;
    logic req_q;
    logic line_q;
    logic wr_q;
    logic [`POS_OFF_W-1:0] wadr_q;
    logic [31:0] hrdata_q;
    logic load;
    logic launch;
    logic shifter_idle;
    logic wipe_out_word;
    logic tick;
    logic frame_end;
    logic req_d;

    pos_pin_sync #(.W($bits(pos_pkg::pos_host_in_t))) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_in(host_pin),
        .pin_q(host_s)
    );

    // ------------------------------------------------------------------
    // AHB-Lite slave, zero wait states, always OKAY
    // ------------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp = `POS_HRESP_OKAY;
    assign hrdata = hrdata_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            wadr_q <= '0;
        end else if (hready) begin
            wr_q <= hsel & htrans[`POS_HTRANS_ACTIVE] & hwrite;
            wadr_q <= haddr[`POS_OFF_W-1:0];
        end
    end

    // read data is sampled in the address phase so it stands from a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= '0;
        end else if (hready && hsel && htrans[`POS_HTRANS_ACTIVE] && !hwrite) begin
            hrdata_q <= '0;
            unique case (haddr[`POS_OFF_W-1:0])
                `POS_CTRL_OFF: begin
                    hrdata_q[`POS_B_OFFLINE] <= ctrl_q.offline_flag;
                    hrdata_q[`POS_B_PERF] <= ctrl_q.perforator_active_flag;
                    hrdata_q[`POS_B_KB] <= ctrl_q.keyboard_active;
                    hrdata_q[`POS_B_PRDY] <= ctrl_q.printer_ready_flag;
                end
                `POS_STAT_OFF: begin
                    hrdata_q[`POS_S_SREADY] <= serializer_ready_flag_q;
                    hrdata_q[`POS_S_PEN] <= print_enable_flag_q;
                    hrdata_q[`POS_S_REQ] <= req_q;
                    hrdata_q[`POS_S_LINE] <= line_q;
                    hrdata_q[`POS_S_STOP] <= (state_q == pos_pkg::POS_STOP);
                    hrdata_q[`POS_S_WORD_HI:`POS_S_WORD_LO] <= out_word_q;
                end
                default: hrdata_q <= '0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= `POS_CTRL_RST;
        end else if (wr_q && wadr_q == `POS_CTRL_OFF) begin
            ctrl_q.offline_flag <= hwdata[`POS_B_OFFLINE];
            ctrl_q.perforator_active_flag <= hwdata[`POS_B_PERF];
            ctrl_q.keyboard_active <= hwdata[`POS_B_KB];
            ctrl_q.printer_ready_flag <= hwdata[`POS_B_PRDY];
        end
    end

    // ------------------------------------------------------------------
    // word request and acknowledge
    // ------------------------------------------------------------------
    assign shifter_idle = (state_q == pos_pkg::POS_IDLE) && serializer_ready_flag_q;
    assign load = (load_cnt_q != '0);
    assign wipe_out_word = !print_enable_flag_q && !ctrl_q.keyboard_active;
    assign launch = print_enable_flag_q && !ctrl_q.keyboard_active;
    assign function_word_request_gate = serializer_ready_flag_q;

    always_comb begin
        req_d = ctrl_q.printer_ready_flag && !ctrl_q.perforator_active_flag
                && !ctrl_q.keyboard_active;
        req_d = req_d && shifter_idle;
        req_d = req_d && !ctrl_q.offline_flag;
        req_d = req_d && !print_enable_flag_q && !load;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_q <= 1'b0;
        end else begin
            req_q <= req_d;
        end
    end
    assign out_word_request = req_q;

    // the host holds data steady through the load pulse after its acknowledge edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ack_prev_q <= 1'b0;
            load_cnt_q <= '0;
        end else begin
            ack_prev_q <= host_s.out_word_ack;
            if (host_s.out_word_ack && !ack_prev_q && !ctrl_q.offline_flag && !load) begin
                load_cnt_q <= PULSE_LD;
            end else if (load) begin
                load_cnt_q <= load_cnt_q - 9'h001;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_word_q <= '0;
        end else if (load) begin
            out_word_q <= host_s.out_word;
        end else if (wipe_out_word) begin
            out_word_q <= '0;
        end
    end

    // ------------------------------------------------------------------
    // serializer timing from one prescaled tick
    // ------------------------------------------------------------------
    assign tick = (pre_q == TICK_LAST);
    assign frame_end = tick && (ftk_q == FRAME_LAST);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_q <= '0;
            ftk_q <= '0;
            frame_q <= '0;
        end else if (state_q == pos_pkg::POS_IDLE) begin
            pre_q <= '0;
            ftk_q <= '0;
            frame_q <= `POS_FRAME_START;
        end else begin
            pre_q <= tick ? '0 : pre_q + 16'h0001;
            if (state_q == pos_pkg::POS_SHIFT && frame_end) begin
                ftk_q <= '0;
                frame_q <= frame_q + 4'h1;
            end else if (tick) begin
                ftk_q <= ftk_q + 12'h001;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= pos_pkg::POS_IDLE;
        end else begin
            unique case (state_q)
                pos_pkg::POS_IDLE: begin
                    if (launch && serializer_ready_flag_q) begin
                        state_q <= pos_pkg::POS_SHIFT;
                    end
                end
                pos_pkg::POS_SHIFT: begin
                    if (frame_end && frame_q == `POS_PARITY_FRAME) begin
                        state_q <= pos_pkg::POS_STOP;
                    end
                end
                pos_pkg::POS_STOP: begin
                    if (tick && ftk_q == STOP_LAST) begin
                        state_q <= pos_pkg::POS_IDLE;
                    end
                end
                default: state_q <= pos_pkg::POS_IDLE;
            endcase
        end
    end

    // ready drops one pulse width after the start trigger
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serializer_ready_flag_q <= 1'b1;
            trig_cnt_q <= '0;
        end else if (state_q == pos_pkg::POS_IDLE && launch && serializer_ready_flag_q) begin
            trig_cnt_q <= PULSE_LD;
        end else if (trig_cnt_q != '0) begin
            trig_cnt_q <= trig_cnt_q - 9'h001;
            if (trig_cnt_q == 9'h001) begin
                serializer_ready_flag_q <= 1'b0;
            end
        end else if (state_q == pos_pkg::POS_SHIFT && frame_end
                     && frame_q == `POS_PARITY_FRAME) begin
            serializer_ready_flag_q <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            print_enable_flag_q <= 1'b0;
        end else if (state_q == pos_pkg::POS_SHIFT && frame_end
                     && frame_q == `POS_PARITY_FRAME) begin
            print_enable_flag_q <= 1'b0;
        end else if (load && ctrl_q.printer_ready_flag) begin
            print_enable_flag_q <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_q <= `POS_MARK;
        end else if (state_q == pos_pkg::POS_SHIFT) begin
            line_q <= frame_level(frame_q, out_word_q);
        end else begin
            line_q <= `POS_MARK;
        end
    end
    assign printer_serial_line = line_q;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    logic [31:0] cyc_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cyc_q <= '0;
        end else if (state_q == pos_pkg::POS_IDLE) begin
            cyc_q <= '0;
        end else begin
            cyc_q <= cyc_q + 32'h0000_0001;
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_start;
        $rose(state_q == pos_pkg::POS_SHIFT);
    endsequence
    sequence s_data_frame;
        state_q == pos_pkg::POS_SHIFT && frame_q >= `POS_DATA_FIRST
            && frame_q <= `POS_DATA_LAST;
    endsequence

    a_req_needs_ready: assert property (
        out_word_request |-> $past(ctrl_q.printer_ready_flag && !ctrl_q.keyboard_active))
        else $error("request without printer ready");
    a_req_when_idle: assert property (
        state_q != pos_pkg::POS_IDLE |=> !out_word_request)
        else $error("request while serializer busy");
    a_req_online: assert property (
        ctrl_q.offline_flag |=> !out_word_request)
        else $error("request while off-line");
    a_load_width: assert property (
        $rose(load) |-> load[*8] ##0 (load_cnt_q == PULSE_LD - 9'd7))
        else $error("load pulse width wrong");
    a_enable_ready: assert property (
        $rose(print_enable_flag_q) |-> $past(load && ctrl_q.printer_ready_flag))
        else $error("print enable set without ready");
    a_capture_word: assert property (
        load |=> out_word_q == $past(host_s.out_word))
        else $error("word not captured");
    a_enable_holds: assert property (
        print_enable_flag_q && !load |=> !out_word_request && $stable(out_word_q))
        else $error("word wiped or requested while enabled");
    a_trigger_len: assert property (
        $fell(serializer_ready_flag_q) |-> cyc_q == PULSE_CYC)
        else $error("ready cleared at wrong time");
    a_fwr_blocked: assert property (
        !serializer_ready_flag_q |-> !function_word_request_gate)
        else $error("function word request not blocked");
    a_idle_mark: assert property (
        state_q == pos_pkg::POS_IDLE ##1 state_q == pos_pkg::POS_IDLE |-> line_q)
        else $error("idle line not mark");
    a_start_space: assert property (
        s_start |=> !line_q)
        else $error("start element not space");
    a_frame_step: assert property (
        state_q == pos_pkg::POS_SHIFT && $changed(frame_q) |-> cyc_q % FRAME_CYC == 0)
        else $error("frame length wrong");
    a_data_level: assert property (
        s_data_frame |=> line_q == $past(out_word_q[3'(frame_q - `POS_DATA_FIRST)]))
        else $error("data bit level wrong");
    a_parity_space: assert property (
        state_q == pos_pkg::POS_SHIFT && frame_q == `POS_PARITY_FRAME |=> !line_q)
        else $error("parity frame not space");
    a_stop_entry: assert property (
        $rose(serializer_ready_flag_q) |-> state_q == pos_pkg::POS_STOP
            && !print_enable_flag_q && cyc_q == 9 * FRAME_CYC)
        else $error("stop entry wrong");

endmodule : pos_serializer

/* test/pos_host_model.sv */
// host output channel and teleprinter receiver model for the serializer bench
`timescale 1ns/1ps
module pos_host_model #(
    parameter int TICK_CYC = 2
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic out_word_request,
    input wire logic printer_serial_line,
    input wire logic host_en,
    input wire logic ack_anyway,
    input wire logic [7:0] word,
    input wire logic [15:0] ack_delay,
    output pos_pkg::pos_host_in_t host_pin,
    output logic [9:0] rx_bits,
    output int rx_start_len,
    output int rx_count
);
    localparam int FRAME = TICK_CYC * 909;
    logic ack_q;
    logic [7:0] data_q;
    int run;
    bit in_run;

    // ------------------------------------------------------------------
    // host side
    // ------------------------------------------------------------------
    // a stray acknowledge bypasses the request handshake on purpose
    assign host_pin = {ack_q | ack_anyway, (ack_anyway ? word : data_q)};

    initial begin
        ack_q = 1'b0;
        data_q = 8'h00;
        forever begin
            @(posedge hclk);
            if (host_en && out_word_request === 1'b1) begin
                repeat (ack_delay) @(posedge hclk);
                data_q <= word;
                @(posedge hclk);
                ack_q <= 1'b1;
                while (out_word_request !== 1'b0) @(posedge hclk);
                // data stands through the load, then the lines stop holding it
                repeat (500) @(posedge hclk);
                ack_q <= 1'b0;
                data_q <= ~word;
            end
        end
    end

    // ------------------------------------------------------------------
    // teleprinter receiver: samples mid-frame, measures the start run
    // ------------------------------------------------------------------
    initial begin
        rx_count = 0;
        rx_bits = '0;
        rx_start_len = 0;
        forever begin
            @(posedge hclk);
            if (hresetn === 1'b1 && printer_serial_line === 1'b0) begin
                run = 1;
                in_run = 1'b1;
                for (int t = 1; t <= 9 * FRAME + FRAME / 2; t++) begin
                    @(posedge hclk);
                    if (in_run && printer_serial_line === 1'b0) run++;
                    else in_run = 1'b0;
                    if (t % FRAME == FRAME / 2) rx_bits[t / FRAME] = printer_serial_line;
                end
                rx_start_len = run;
                rx_count++;
            end
        end
    end
endmodule : pos_host_model

/* test/tb_top.sv */
// self-checking bench for the printer output serializer
`timescale 1ns/1ps
`include "pos_cfg.svh"
module tb_top;
    localparam int TICK = 2;
    localparam int FRAME = TICK * 909;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic out_word_request, printer_serial_line, function_word_request_gate;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    pos_pkg::pos_host_in_t host_pin;
    logic host_en, ack_anyway;
    logic [7:0] word;
    logic [15:0] ack_delay;
    logic [9:0] rx_bits;
    int rx_start_len, rx_count, num_errors, num_checks, n, cnt0;

    assign hready = hreadyout;

    pos_serializer #(.TICK_CYC(TICK)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .host_pin(host_pin), .out_word_request(out_word_request),
        .printer_serial_line(printer_serial_line),
        .function_word_request_gate(function_word_request_gate));

    pos_host_model #(.TICK_CYC(TICK)) u_host (.hclk(hclk), .hresetn(hresetn),
        .out_word_request(out_word_request), .printer_serial_line(printer_serial_line),
        .host_en(host_en), .ack_anyway(ack_anyway), .word(word), .ack_delay(ack_delay),
        .host_pin(host_pin), .rx_bits(rx_bits), .rx_start_len(rx_start_len),
        .rx_count(rx_count));

    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask : check

    task stop_test;
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test

    // one single word transfer; read data lands in rd
    task ahb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h000000, addr};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'b010;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : ahb

    // follows one character from launch to the end of its stop window
    task char_cycle(input logic [7:0] w, input logic [7:0] nw, input logic [15:0] nd,
                    input logic ne);
        n = 0;
        while (printer_serial_line !== 1'b0 && n < 4000) begin
            @(posedge hclk);
            n++;
        end
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (function_word_request_gate !== 1'b0 && n < 1000);
        check(32'(n), 32'd399);
        ahb(1'b0, `POS_STAT_OFF, 32'h0);
        check(rd, {16'h0000, w, 8'h02});
        cnt0 = rx_count;
        n = 0;
        while (rx_count == cnt0 && n < 12 * FRAME) begin
            @(posedge hclk);
            n++;
        end
        word <= nw;
        ack_delay <= nd;
        host_en <= ne;
        check(32'(rx_bits), 32'({1'b1, 1'b0, w[6:0], 1'b0}));
        if (w[0]) check(32'(rx_start_len), 32'(FRAME));
        ahb(1'b0, `POS_STAT_OFF, 32'h0);
        check(rd, 32'h0000_0019);
        n = 0;
        repeat (2600) begin
            @(posedge hclk);
            if (out_word_request !== 1'b0) n++;
        end
        check(32'(n), 32'h0);
        n = 0;
        while (out_word_request !== 1'b1 && n < 400) begin
            @(posedge hclk);
            n++;
        end
        check(32'(out_word_request), 32'h1);
    endtask : char_cycle

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        host_en = 1'b0;
        ack_anyway = 1'b0;
        word = 8'h00;
        ack_delay = 16'h0;
        num_errors = 0;
        num_checks = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check(32'({hreadyout, hresp, out_word_request, printer_serial_line,
                   function_word_request_gate}), 32'h13);
        ahb(1'b0, `POS_CTRL_OFF, 32'h0);
        check(rd, 32'h0);
        ahb(1'b0, `POS_STAT_OFF, 32'h0);
        check(rd, 32'h0000_0009);
        ahb(1'b0, 8'h08, 32'h0);
        check(rd, 32'h0);
        ahb(1'b1, `POS_STAT_OFF, 32'hFFFF_FFFF);
        ahb(1'b0, `POS_STAT_OFF, 32'h0);
        check(rd, 32'h0000_0009);
        // every combination of the four request qualifiers
        for (int c = 0; c < 16; c++) begin
            ahb(1'b1, `POS_CTRL_OFF, 32'(c));
            repeat (4) @(posedge hclk);
            check(32'(out_word_request), 32'(c == 8));
        end
        // stray acknowledge while off-line must not load
        ahb(1'b1, `POS_CTRL_OFF, 32'h9);
        word <= 8'h3C;
        ack_anyway <= 1'b1;
        repeat (20) @(posedge hclk);
        ack_anyway <= 1'b0;
        repeat (10) @(posedge hclk);
        ahb(1'b0, `POS_STAT_OFF, 32'h0);
        check(rd, 32'h0000_0009);
        // load without printer ready: captured, but no print enable
        ahb(1'b1, `POS_CTRL_OFF, 32'h4);
        word <= 8'hA5;
        ack_anyway <= 1'b1;
        repeat (600) @(posedge hclk);
        ahb(1'b0, `POS_STAT_OFF, 32'h0);
        check(rd, 32'h0000_A509);
        ack_anyway <= 1'b0;
        ahb(1'b1, `POS_CTRL_OFF, 32'h0);
        repeat (4) @(posedge hclk);
        ahb(1'b0, `POS_STAT_OFF, 32'h0);
        check(rd, 32'h0000_0009);
        // keyboard holds the launch back until it goes inactive
        ahb(1'b1, `POS_CTRL_OFF, 32'hC);
        word <= 8'h33;
        ack_anyway <= 1'b1;
        repeat (600) @(posedge hclk);
        ahb(1'b0, `POS_STAT_OFF, 32'h0);
        check(rd, 32'h0000_330B);
        ack_anyway <= 1'b0;
        repeat (2) @(posedge hclk);
        ahb(1'b1, `POS_CTRL_OFF, 32'h8);
        char_cycle(8'h33, 8'hD5, 16'h0, 1'b1);
        // prompt host, then slow host, then host stops answering
        char_cycle(8'hD5, 8'h2A, 16'd300, 1'b1);
        char_cycle(8'h2A, 8'h00, 16'h0, 1'b0);
        stop_test();
    end

    initial begin
        repeat (100000) @(posedge hclk);
        num_errors++;
        stop_test();
    end
endmodule : tb_top
